/* File: design/wkpcrc_match.sv */
// file: masked crc accumulator and comparator for one wake-up pattern
`timescale 1ns/10ps
`default_nettype none

module wkpcrc_match
   import wkpcrc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // pattern setup
   input wire logic detect_en,
   input wire logic [63:0] byte_mask,
   input wire logic [31:0] expect_crc,
   // received byte stream
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic [6:0] byte_idx,
   input wire logic rx_last,
   input wire logic rx_good,
   // result
   output logic match
);

   typedef struct packed {
      logic [31:0] crc;
      logic match;
   } wkpcrc_unit_t;

   wkpcrc_unit_t s_q;
   wkpcrc_unit_t s_d;
   logic sel;
   logic [31:0] crc_in;
   logic [31:0] crc_nx;

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   // byte index 0 restarts the crc, so a dropped frame needs no flush
   always_comb begin
      s_d = s_q;
      s_d.match = 1'b0;
      crc_in = (byte_idx == 7'h00) ? CRC_INIT : s_q.crc;
      sel = (byte_idx < MASK_BYTES) && byte_mask[byte_idx[5:0]];
      crc_nx = sel ? wkpcrc_byte(crc_in, rx_data) : crc_in;
      if (rx_valid) begin
         s_d.crc = crc_nx;
         if (rx_last) begin
            // fcs is the complement of the running register
            s_d.match = detect_en && rx_good && (~crc_nx == expect_crc);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign match = s_q.match;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_unmasked_skip;
      rx_valid && byte_idx != 7'h00 && !sel |=> $stable(s_q.crc);
   endproperty
   a_unmasked_skip: assert property (p_unmasked_skip)
      else $error("unselected byte changed the crc");

   property p_beyond_window;
      rx_valid && byte_idx >= 7'h40 |=> s_q.crc == $past(s_q.crc);
   endproperty
   a_beyond_window: assert property (p_beyond_window)
      else $error("byte past 64 entered the crc");

   property p_match_cause;
      match |-> $past(rx_valid && rx_last && rx_good && detect_en);
   endproperty
   a_match_cause: assert property (p_match_cause)
      else $error("match without good enabled frame end");

endmodule
`default_nettype wire

/* File: design/wkpcrc_pkg.sv */
// package: register map, field codes, reset values and crc helpers
package wkpcrc_pkg;

   // -----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_WAKE_CTRL = 8'h2A;
   localparam logic [7:0] IDX_PATTERN0_CRC_LOW = 8'h30;
   localparam logic [7:0] IDX_PATTERN0_CRC_HIGH = 8'h32;
   localparam logic [7:0] IDX_PATTERN0_MASK_WORD0 = 8'h34;
   localparam logic [7:0] IDX_PATTERN0_MASK_WORD1 = 8'h36;
   localparam logic [7:0] IDX_PATTERN0_MASK_WORD2 = 8'h38;
   localparam logic [7:0] IDX_PATTERN0_MASK_WORD3 = 8'h3A;
   localparam logic [7:0] IDX_PATTERN1_CRC_LOW = 8'h40;
   localparam logic [7:0] IDX_PATTERN1_CRC_HIGH = 8'h42;
   localparam logic [7:0] IDX_PATTERN1_MASK_WORD0 = 8'h44;
   localparam logic [7:0] IDX_PATTERN1_MASK_WORD1 = 8'h46;
   localparam logic [7:0] IDX_PATTERN1_MASK_WORD2 = 8'h48;
   localparam logic [7:0] IDX_PATTERN1_MASK_WORD3 = 8'h4A;
   localparam logic [7:0] IDX_PATTERN2_CRC_LOW = 8'h50;
   localparam logic [7:0] IDX_PATTERN2_CRC_HIGH = 8'h52;
   localparam logic [7:0] IDX_PATTERN2_MASK_WORD0 = 8'h54;
   localparam logic [7:0] IDX_PATTERN2_MASK_WORD1 = 8'h56;
   localparam logic [7:0] IDX_PATTERN2_MASK_WORD2 = 8'h58;
   localparam logic [7:0] IDX_PATTERN2_MASK_WORD3 = 8'h5A;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h5C;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h5D;

   // -----------------------------------------------------------------
   // field codes returned by the slot decoder
   // -----------------------------------------------------------------
   localparam logic [3:0] FLD_CRC_LOW = 4'h0;
   localparam logic [3:0] FLD_CRC_HIGH = 4'h1;
   localparam logic [3:0] FLD_MASK_WORD0 = 4'h2;
   localparam logic [3:0] FLD_MASK_WORD1 = 4'h3;
   localparam logic [3:0] FLD_MASK_WORD2 = 4'h4;
   localparam logic [3:0] FLD_MASK_WORD3 = 4'h5;
   localparam logic [3:0] FLD_WAKE_CTRL = 4'h6;
   localparam logic [3:0] FLD_IRQ_STATUS = 4'h7;
   localparam logic [3:0] FLD_IRQ_MASK = 4'h8;

   // -----------------------------------------------------------------
   // sizes, reset values, bus answers, crc constants
   // -----------------------------------------------------------------
   localparam int NUM_PATTERNS = 3;
   localparam logic [6:0] MASK_BYTES = 7'h40;
   localparam logic [15:0] RST_HALF = 16'h0000;
   localparam logic [2:0] RST_BITS = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] CRC_POLY_REFL = 32'hEDB8_8320;
   localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;

   typedef struct packed {
      logic hit;
      logic [1:0] pat;
      logic [3:0] fld;
   } wkpcrc_slot_t;

   // map a word index onto pattern and field
   function automatic wkpcrc_slot_t wkpcrc_slot(input logic [7:0] idx);
      wkpcrc_slot_t s;
      s = '0;
      s.hit = 1'b1;
      case (idx)
         IDX_WAKE_CTRL: s.fld = FLD_WAKE_CTRL;
         IDX_IRQ_STATUS: s.fld = FLD_IRQ_STATUS;
         IDX_IRQ_MASK: s.fld = FLD_IRQ_MASK;
         IDX_PATTERN0_CRC_LOW: s.fld = FLD_CRC_LOW;
         IDX_PATTERN0_CRC_HIGH: s.fld = FLD_CRC_HIGH;
         IDX_PATTERN0_MASK_WORD0: s.fld = FLD_MASK_WORD0;
         IDX_PATTERN0_MASK_WORD1: s.fld = FLD_MASK_WORD1;
         IDX_PATTERN0_MASK_WORD2: s.fld = FLD_MASK_WORD2;
         IDX_PATTERN0_MASK_WORD3: s.fld = FLD_MASK_WORD3;
         IDX_PATTERN1_CRC_LOW: s = '{1'b1, 2'h1, FLD_CRC_LOW};
         IDX_PATTERN1_CRC_HIGH: s = '{1'b1, 2'h1, FLD_CRC_HIGH};
         IDX_PATTERN1_MASK_WORD0: s = '{1'b1, 2'h1, FLD_MASK_WORD0};
         IDX_PATTERN1_MASK_WORD1: s = '{1'b1, 2'h1, FLD_MASK_WORD1};
         IDX_PATTERN1_MASK_WORD2: s = '{1'b1, 2'h1, FLD_MASK_WORD2};
         IDX_PATTERN1_MASK_WORD3: s = '{1'b1, 2'h1, FLD_MASK_WORD3};
         IDX_PATTERN2_CRC_LOW: s = '{1'b1, 2'h2, FLD_CRC_LOW};
         IDX_PATTERN2_CRC_HIGH: s = '{1'b1, 2'h2, FLD_CRC_HIGH};
         IDX_PATTERN2_MASK_WORD0: s = '{1'b1, 2'h2, FLD_MASK_WORD0};
         IDX_PATTERN2_MASK_WORD1: s = '{1'b1, 2'h2, FLD_MASK_WORD1};
         IDX_PATTERN2_MASK_WORD2: s = '{1'b1, 2'h2, FLD_MASK_WORD2};
         IDX_PATTERN2_MASK_WORD3: s = '{1'b1, 2'h2, FLD_MASK_WORD3};
         default: s.hit = 1'b0;
      endcase
      return s;
   endfunction

   // byte-lane merge of a 16-bit field
   function automatic logic [15:0] wkpcrc_merge(input logic [15:0] old,
         input logic [15:0] nw, input logic [1:0] strb);
      return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
   endfunction

   // reflected ethernet crc, one byte, lsb first
   function automatic logic [31:0] wkpcrc_byte(input logic [31:0] crc,
         input logic [7:0] data);
      logic [31:0] c;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         c = (c[0] ^ data[i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
      end
      return c;
   endfunction

endpackage

/* File: design/wkpcrc_regs.sv */
// file: wake-up pattern crc and byte mask registers with axi4-lite slave
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - crc32 is taken only over frame bytes whose mask bit is set
// - crc high register holds expected crc bits 31 to 16, read/write
// - crc low register holds expected crc bits 15 to 0, read/write
// - mask word 0 bits 0..15 select frame bytes 1..16
// - mask word 1 bits 0..15 select frame bytes 17..32
// - mask word 2 bits 0..15 select frame bytes 33..48
// - mask word 3 bits 0..15 select bytes 49..64; nothing beyond
// - a pattern is only detected while its enable bit is set
module wkpcrc_regs
   import wkpcrc_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // axi4-lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // axi4-lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // received frame bytes
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic rx_good,
   // wake-up events
   output logic [2:0] wake_detect,
   output logic irq
);

   typedef struct packed {
      logic [2:0][31:0] crc;
      logic [2:0][63:0] mask;
      logic [2:0] en;
      logic [2:0] sts;
      logic [2:0] msk;
      logic [6:0] cnt;
      logic aw_full;
      logic [7:0] aw_idx;
      logic w_full;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } wkpcrc_state_t;

   wkpcrc_state_t s_q;
   wkpcrc_state_t s_d;
   wkpcrc_slot_t sl_w;
   wkpcrc_slot_t sl_r;
   logic aw_have;
   logic w_have;
   logic wr_go;
   logic rd_go;
   logic [7:0] wr_idx;
   logic [15:0] wr_data;
   logic [1:0] wr_strb;
   logic [15:0] t16;
   logic [2:0] w1c;
   logic [2:0] match_vec;

   // --------------------------------------------------------------
   // bus handshakes
   // --------------------------------------------------------------
   // no new write is taken while a response waits, so one at a time
   assign s_axi_awready = !s_q.aw_full && !s_q.bvalid;
   assign s_axi_wready = !s_q.w_full && !s_q.bvalid;
   assign s_axi_arready = !s_q.rvalid;
   assign aw_have = s_q.aw_full || (s_axi_awvalid && s_axi_awready);
   assign w_have = s_q.w_full || (s_axi_wvalid && s_axi_wready);
   assign wr_go = aw_have && w_have && !s_q.bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign wr_idx = s_q.aw_full ? s_q.aw_idx : s_axi_awaddr[9:2];
   assign wr_data = s_q.w_full ? s_q.wdata : s_axi_wdata[15:0];
   assign wr_strb = s_q.w_full ? s_q.wstrb : s_axi_wstrb[1:0];

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      sl_w = wkpcrc_slot(wr_idx);
      sl_r = wkpcrc_slot(s_axi_araddr[9:2]);
      t16 = RST_HALF;
      w1c = RST_BITS;
      // park a lone address or data beat until its partner arrives
      if (s_axi_awvalid && s_axi_awready && !wr_go) begin
         s_d.aw_full = 1'b1;
         s_d.aw_idx = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go) begin
         s_d.w_full = 1'b1;
         s_d.wdata = s_axi_wdata[15:0];
         s_d.wstrb = s_axi_wstrb[1:0];
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      // register write; only the low two byte lanes carry data
      if (wr_go) begin
         s_d.aw_full = 1'b0;
         s_d.w_full = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = sl_w.hit ? RESP_OKAY : RESP_SLVERR;
         if (sl_w.hit) begin
            case (sl_w.fld)
               FLD_CRC_LOW: s_d.crc[sl_w.pat][15:0] =
                  wkpcrc_merge(s_q.crc[sl_w.pat][15:0], wr_data, wr_strb);
               FLD_CRC_HIGH: s_d.crc[sl_w.pat][31:16] =
                  wkpcrc_merge(s_q.crc[sl_w.pat][31:16], wr_data, wr_strb);
               FLD_MASK_WORD0: s_d.mask[sl_w.pat][15:0] =
                  wkpcrc_merge(s_q.mask[sl_w.pat][15:0], wr_data, wr_strb);
               FLD_MASK_WORD1: s_d.mask[sl_w.pat][31:16] =
                  wkpcrc_merge(s_q.mask[sl_w.pat][31:16], wr_data, wr_strb);
               FLD_MASK_WORD2: s_d.mask[sl_w.pat][47:32] =
                  wkpcrc_merge(s_q.mask[sl_w.pat][47:32], wr_data, wr_strb);
               FLD_MASK_WORD3: s_d.mask[sl_w.pat][63:48] =
                  wkpcrc_merge(s_q.mask[sl_w.pat][63:48], wr_data, wr_strb);
               FLD_WAKE_CTRL: begin
                  t16 = wkpcrc_merge({13'h0000, s_q.en}, wr_data, wr_strb);
                  s_d.en = t16[2:0];
               end
               FLD_IRQ_STATUS: w1c = wr_data[2:0] & {3{wr_strb[0]}};
               FLD_IRQ_MASK: begin
                  t16 = wkpcrc_merge({13'h0000, s_q.msk}, wr_data, wr_strb);
                  s_d.msk = t16[2:0];
               end
               default: s_d.bresp = RESP_SLVERR;
            endcase
         end
      end
      // a detection in the clearing cycle survives the clear
      s_d.sts = (s_q.sts & ~w1c) | match_vec;
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      // register read; unused upper bits read as zero
      if (rd_go) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = sl_r.hit ? RESP_OKAY : RESP_SLVERR;
         s_d.rdata = 32'h0000_0000;
         if (sl_r.hit) begin
            case (sl_r.fld)
               FLD_CRC_LOW: s_d.rdata[15:0] = s_q.crc[sl_r.pat][15:0];
               FLD_CRC_HIGH: s_d.rdata[15:0] = s_q.crc[sl_r.pat][31:16];
               FLD_MASK_WORD0: s_d.rdata[15:0] = s_q.mask[sl_r.pat][15:0];
               FLD_MASK_WORD1: s_d.rdata[15:0] = s_q.mask[sl_r.pat][31:16];
               FLD_MASK_WORD2: s_d.rdata[15:0] = s_q.mask[sl_r.pat][47:32];
               FLD_MASK_WORD3: s_d.rdata[15:0] = s_q.mask[sl_r.pat][63:48];
               FLD_WAKE_CTRL: s_d.rdata[2:0] = s_q.en;
               FLD_IRQ_STATUS: s_d.rdata[2:0] = s_q.sts;
               FLD_IRQ_MASK: s_d.rdata[2:0] = s_q.msk;
               default: s_d.rresp = RESP_SLVERR;
            endcase
         end
      end
      // frame byte position; saturates past the mask window
      if (rx_valid) begin
         if (rx_last) begin
            s_d.cnt = 7'h00;
         end else if (s_q.cnt != MASK_BYTES) begin
            s_d.cnt = s_q.cnt + 7'h01;
         end
      end
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // --------------------------------------------------------------
   // pattern matchers
   // --------------------------------------------------------------
   // all three see the same stream; each has its own mask and crc
   for (genvar p = 0; p < NUM_PATTERNS; p++) begin : g_pat
      wkpcrc_match u_match (
         .aclk(aclk),
         .aresetn(aresetn),
         .detect_en(s_q.en[p]),
         .byte_mask(s_q.mask[p]),
         .expect_crc(s_q.crc[p]),
         .rx_valid(rx_valid),
         .rx_data(rx_data),
         .byte_idx(s_q.cnt),
         .rx_last(rx_last),
         .rx_good(rx_good),
         .match(match_vec[p])
      );
   end

   // --------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign wake_detect = match_vec;
   assign irq = |(s_q.sts & s_q.msk);

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_crc_high_write;
      wr_go && wr_idx == IDX_PATTERN0_CRC_HIGH && wr_strb == 2'h3
         |=> s_q.crc[0][31:16] == $past(wr_data);
   endproperty
   a_crc_high_write: assert property (p_crc_high_write)
      else $error("crc high half not stored");

   property p_crc_low_write;
      wr_go && wr_idx == IDX_PATTERN1_CRC_LOW && wr_strb == 2'h3
         |=> s_q.crc[1][15:0] == $past(wr_data) && $stable(s_q.crc[1][31:16]);
   endproperty
   a_crc_low_write: assert property (p_crc_low_write)
      else $error("crc low half not stored");

   property p_mask0_write;
      wr_go && wr_idx == IDX_PATTERN2_MASK_WORD0 && wr_strb == 2'h3
         |=> s_q.mask[2][15:0] == $past(wr_data);
   endproperty
   a_mask0_write: assert property (p_mask0_write)
      else $error("mask word 0 not in bytes 1 to 16");

   property p_mask3_write;
      wr_go && wr_idx == IDX_PATTERN1_MASK_WORD3 && wr_strb == 2'h3
         |=> s_q.mask[1][63:48] == $past(wr_data);
   endproperty
   a_mask3_write: assert property (p_mask3_write)
      else $error("mask word 3 not in bytes 49 to 64");

   property p_enable_gate;
      wake_detect[1] |-> $past(s_q.en[1]);
   endproperty
   a_enable_gate: assert property (p_enable_gate)
      else $error("detection while pattern disabled");

   property p_detect_sticky;
      wake_detect[2] |=> s_q.sts[2] ##1 (s_q.sts[2] || $past(w1c[2]));
   endproperty
   a_detect_sticky: assert property (p_detect_sticky)
      else $error("detection not held in status");

   property p_read_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_read_hold: assert property (p_read_hold)
      else $error("read data dropped before rready");

   property p_write_answer;
      wr_go |=> s_axi_bvalid ##0 !s_axi_awready && !s_axi_wready;
   endproperty
   a_write_answer: assert property (p_write_answer)
      else $error("write not answered next cycle");

   property p_read_answer;
      rd_go |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read not answered next cycle");

   property p_mask1_write;
      wr_go && wr_idx == IDX_PATTERN0_MASK_WORD1 && wr_strb == 2'h3
         |=> s_q.mask[0][31:16] == $past(wr_data);
   endproperty
   a_mask1_write: assert property (p_mask1_write)
      else $error("mask word 1 not in bytes 17 to 32");

   property p_mask2_write;
      wr_go && wr_idx == IDX_PATTERN1_MASK_WORD2 && wr_strb == 2'h3
         |=> s_q.mask[1][47:32] == $past(wr_data);
   endproperty
   a_mask2_write: assert property (p_mask2_write)
      else $error("mask word 2 not in bytes 33 to 48");

   property p_enable_write;
      wr_go && wr_idx == IDX_WAKE_CTRL && wr_strb[0]
         |=> s_q.en == $past(wr_data[2:0]);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("enable bits not stored");

   property p_frame_restart;
      rx_valid && rx_last |=> s_q.cnt == 7'h00;
   endproperty
   a_frame_restart: assert property (p_frame_restart)
      else $error("byte position not restarted after frame end");

   property p_bad_write;
      wr_go && !sl_w.hit |=> s_axi_bresp == RESP_SLVERR;
   endproperty
   a_bad_write: assert property (p_bad_write)
      else $error("unmapped write not refused");

   property p_bad_read;
      rd_go && !sl_r.hit
         |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
   endproperty
   a_bad_read: assert property (p_bad_read)
      else $error("unmapped read not refused");

endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the wake-up pattern register bank
`timescale 1ns/10ps
`default_nettype none

module tb
   import wkpcrc_pkg::*;
;
   // ----------
   // signals and instances
   // ----------
   localparam logic [63:0] SEL = 64'h8001_8001_8001_8001;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [9:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, crc;
   logic [3:0] wstrb = '0;
   logic [1:0] bresp, rresp;
   logic rx_valid, rx_last, rx_good;
   logic [7:0] rx_data, ix;
   logic [15:0] v;
   logic [2:0] wake_detect;
   int failures = 0, num_checks = 0, cyc = 0;
   int flips [11] = '{-1, 1, 64, 0, 15, 16, 31, 32, 47, 48, 63};

   always #50 aclk = ~aclk;

   wkpcrc_regs #(.ADDR_W(10)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .rx_good(rx_good), .wake_detect(wake_detect), .irq(irq));

   wkpcrc_rx_src u_src (.aclk(aclk), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_last(rx_last), .rx_good(rx_good));

   // ----------
   // verdict, comparison and bus tasks
   // ----------
   task automatic stop_test();
      if (failures == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask

   // address and data offered together; each dropped once it is taken
   task automatic wr(input logic [7:0] idx, input logic [31:0] d,
         input logic [3:0] st, input logic [1:0] er);
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= {idx, 2'b00};
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= st;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] ed,
         input logic [1:0] er);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= {idx, 2'b00};
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk("rdata", ed, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask

   // the detect pulse stands only in the cycle after the last byte
   task automatic frame(input int n, input logic good, input int flip,
         input logic [2:0] ew);
      u_src.send(n, good, flip);
      #1;
      chk("wake_detect", {29'h0, ew}, {29'h0, wake_detect});
   endtask

   // fcs of the selected bytes, worked out bit by bit, lsb first
   function automatic logic [31:0] fcs();
      logic [31:0] c;
      logic [7:0] b;
      c = 32'hFFFF_FFFF;
      for (int i = 0; i < 64; i++) begin
         b = u_src.byte_at(i, -1);
         for (int k = 0; k < 8; k++) begin
            if (SEL[i]) begin
               c = (c[0] ^ b[k]) ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
            end
         end
      end
      return ~c;
   endfunction

   // ----------
   // main sequence
   // ----------
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      crc = fcs();
      // reset value, full-width write and readback, then the working value of each field
      for (int p = 0; p < 3; p++) begin
         for (int r = 0; r < 12; r += 2) begin
            ix = 8'(8'h30 + 16 * p + r);
            v = (r == 0) ? crc[15:0] : (r == 2) ? crc[31:16] : 16'h8001;
            rd(ix, 32'h0, RESP_OKAY);
            wr(ix, {16'hFFFF, ix, ~ix}, 4'hF, RESP_OKAY);
            rd(ix, {16'h0, ix, ~ix}, RESP_OKAY);
            wr(ix, {16'h0, v}, 4'h3, RESP_OKAY);
         end
      end
      // single lane write leaves the other byte alone
      wr(8'h54, 32'hFFFF_FF7E, 4'h1, RESP_OKAY);
      rd(8'h54, 32'h807E, RESP_OKAY);
      wr(8'h54, 32'h8001, 4'h3, RESP_OKAY);
      // reserved word: refused both ways
      wr(8'h3C, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      rd(8'h3C, 32'h0, RESP_SLVERR);
      // one pattern enabled at a time; pattern 2 masked from the irq
      wr(8'h5D, 32'h3, 4'h1, RESP_OKAY);
      for (int p = 0; p < 3; p++) begin
         wr(8'h2A, 32'(1 << p), 4'h1, RESP_OKAY);
         frame(70, 1'b1, -1, 3'(1 << p));
         @(posedge aclk);
         #1;
         chk("irq", 32'(p != 2), {31'h0, irq});
         rd(8'h5C, 32'(1 << p), RESP_OKAY);
         wr(8'h5C, 32'(1 << p), 4'h1, RESP_OKAY);
         rd(8'h5C, 32'h0, RESP_OKAY);
         chk("irq", 32'h0, {31'h0, irq});
      end
      // corrupt one byte: only selected positions up to 64 may matter
      wr(8'h2A, 32'h7, 4'h1, RESP_OKAY);
      foreach (flips[i]) begin
         frame(70, 1'b1, flips[i], (flips[i] >= 0 && flips[i] < 64 &&
            SEL[flips[i]]) ? 3'h0 : 3'h7);
      end
      frame(70, 1'b0, -1, 3'h0);
      frame(64, 1'b1, -1, 3'h7);
      wr(8'h2A, 32'h0, 4'h1, RESP_OKAY);
      frame(70, 1'b1, -1, 3'h0);
      rd(8'h2A, 32'h0, RESP_OKAY);
      stop_test();
   end

   // hang guard, well above the roughly 1500 cycles the run needs
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         failures++;
         stop_test();
      end
   end
endmodule

`default_nettype wire

/* File: tb/wkpcrc_rx_src.sv */
// receive byte stream model standing in for the mac receive path
`timescale 1ns/10ps
`default_nettype none

module wkpcrc_rx_src (
   // clock
   input wire logic aclk,
   // received bytes
   output var logic rx_valid,
   output var logic [7:0] rx_data,
   output var logic rx_last,
   output var logic rx_good
);
   // ----------
   // idle state and frame content
   // ----------
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_last = 1'b0;
      rx_good = 1'b0;
   end

   // byte at position i; flip inverts one byte so a match can be broken
   function automatic logic [7:0] byte_at(input int i, input int flip);
      logic [7:0] b;
      b = 8'(i * 37 + 5);
      return (i == flip) ? ~b : b;
   endfunction

   // ----------
   // one frame, byte 1 first, status given with the last byte only
   // ----------
   task automatic send(input int n, input logic good, input int flip);
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         rx_valid <= 1'b1;
         rx_data <= byte_at(i, flip);
         rx_last <= (i == n - 1);
         rx_good <= good & (i == n - 1);
      end
      @(posedge aclk);
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_good <= 1'b0;
      rx_data <= ~rx_data;  // idle lines must not look like a held byte
   endtask
endmodule

`default_nettype wire
